//--- hw/ctm_defines.svh
`ifndef CTM_DEFINES_SVH
`define CTM_DEFINES_SVH

// register byte addresses
`define CTM_OFF_CTRL0     8'h00
`define CTM_OFF_CTRL1     8'h04
`define CTM_OFF_CNT_LO    8'h08
`define CTM_OFF_CNT_HI    8'h0c
`define CTM_OFF_MA_LO     8'h10
`define CTM_OFF_MA_HI     8'h14
`define CTM_OFF_CMP_P     8'h18
`define CTM_OFF_FLAGS     8'h1c

// reset values
`define CTM_CTRL0_RESET   8'h00
`define CTM_CTRL1_RESET   8'h00
`define CTM_MA_RESET      10'h000
`define CTM_CMP_P_RESET   3'h0
`define CTM_CNT_RESET     10'h000

// control register zero fields
`define CTM_C0_RUN        3
`define CTM_C0_CK_HI      6
`define CTM_C0_CK_LO      4

// control register one fields
`define CTM_C1_MODE_HI    7
`define CTM_C1_MODE_LO    6
`define CTM_C1_ACT_HI     5
`define CTM_C1_ACT_LO     4
`define CTM_C1_OLC        3
`define CTM_C1_INV        2
`define CTM_C1_SWAP       1
`define CTM_C1_CSEL       0

// flag register fields
`define CTM_FL_A          0
`define CTM_FL_P          1

// mode select codes
`define CTM_MODE_CMP      2'h0
`define CTM_MODE_PWM      2'h2
`define CTM_MODE_TMR      2'h3

// pin action codes
`define CTM_ACT_NONE      2'h0
`define CTM_ACT_LOW       2'h1
`define CTM_ACT_HIGH      2'h2
`define CTM_ACT_TOGGLE    2'h3

// timer clock select codes
`define CTM_CK_DIV4       3'h0
`define CTM_CK_DIV1       3'h1
`define CTM_CK_DIV16      3'h2
`define CTM_CK_DIV64      3'h3

// counter limits
`define CTM_CNT_MAX       10'h3ff
`define CTM_FULL_PERIOD   11'h400
`define CTM_P_SHIFT       7
`define CTM_DIV_MIN       6

`endif

//--- hw/ctm_pkg.sv
package ctm_pkg;

  typedef enum logic [1:0] {
    CTM_MD_CMP,
    CTM_MD_TMR,
    CTM_MD_PWM
  } ctm_mode_t;

endpackage

//--- hw/ctm_tick.sv
`timescale 1ns/1ps
`include "ctm_defines.svh"

// timer clock prescaler: one-cycle tick at the selected rate
module ctm_tick
  import ctm_pkg::*;
#(
  parameter int DIV_W = 6
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [2:0] i_sel,
  output logic            o_tick
);

  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] next_div;
  logic             next_tick;

  if (DIV_W < `CTM_DIV_MIN)
  begin : g_chk
    $error("ctm_tick: DIV_W too small for divide by 64");
  end

  always_comb
  begin
    next_div = div + {{(DIV_W-1){1'b0}}, 1'b1};
    case (i_sel)
      `CTM_CK_DIV4:  next_tick = &div[1:0];
      `CTM_CK_DIV16: next_tick = &div[3:0];
      `CTM_CK_DIV64: next_tick = &div[5:0];
      default:       next_tick = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      div    <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      div    <= next_div;
      o_tick <= next_tick;
    end
  end

endmodule

//--- hw/ctm_top.sv
// What this block does
// - compare A is ten bits over two bytes
// - mode bits pick compare, PWM or timer
// - clear select low: P match clears, both flags
// - clear select high: A match clears, no P flag
// - compare A zero with clear select high: wrap at 3FF, no A flag
// - compare mode: only A match moves pin
// - A match sets, clears or toggles pin
// - run rising edge loads initial pin level
// - timer mode counts like compare, pin undriven
// - PWM ignores clear select, swap picks roles
// - PWM raises A and P flags on matches
// - PWM polarity, force levels and invert apply
// - swap clear: period P times 128 or 1024
// - duty not below period gives full duty
// - swap set: period A, duty P times 128
// - counting continues while pin is forced
// - pin action codes per mode
// - clear select 0 is P, 1 is A
// - invert bit flips pin, not in timer mode
`timescale 1ns/1ps
`include "ctm_defines.svh"

module ctm_top
  import ctm_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_PIN,
  output logic             O_PIN_OE
);

  logic [7:0]  ctrl0;
  logic [7:0]  ctrl1;
  logic [9:0]  ma;
  logic [2:0]  cp;
  logic        flag_a;
  logic        flag_p;
  logic [9:0]  cnt;
  logic        run_d;
  logic        pin_level;
  logic [7:0]  next_ctrl0;
  logic [7:0]  next_ctrl1;
  logic [9:0]  next_ma;
  logic [2:0]  next_cp;
  logic        next_flag_a;
  logic        next_flag_p;
  logic [9:0]  next_cnt;
  logic        next_pin_level;
  logic        next_pin;
  logic        next_pin_oe;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        tick;
  logic        run;
  logic        run_rise;
  logic        step;
  logic        wr;
  logic        rd;
  logic        acc;
  ctm_mode_t   mode;
  logic [1:0]  act;
  logic        olc;
  logic        inv;
  logic        swap;
  logic        csel;
  logic [10:0] cnt11;
  logic [10:0] p_len;
  logic [10:0] a_len;
  logic [10:0] per_len;
  logic [10:0] duty_len;
  logic        a_hit;
  logic        p_hit;
  logic        ovf;
  logic        clr;
  logic        set_a;
  logic        set_p;
  logic        pwm_act;
  logic        lvl;

  ctm_tick #(
    .DIV_W (`CTM_DIV_MIN)
  ) u_tick (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_sel   (ctrl0[`CTM_C0_CK_HI:`CTM_C0_CK_LO]),
    .o_tick  (tick)
  );

  // control decode
  always_comb
  begin
    run      = ctrl0[`CTM_C0_RUN];
    run_rise = run & ~run_d;
    step     = run & tick & ~run_rise;
    act      = ctrl1[`CTM_C1_ACT_HI:`CTM_C1_ACT_LO];
    olc      = ctrl1[`CTM_C1_OLC];
    inv      = ctrl1[`CTM_C1_INV];
    swap     = ctrl1[`CTM_C1_SWAP];
    csel     = ctrl1[`CTM_C1_CSEL];
    if (ctrl1[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO] == `CTM_MODE_PWM)
      mode = CTM_MD_PWM;
    else if (ctrl1[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO] == `CTM_MODE_CMP)
      mode = CTM_MD_CMP;
    else
      mode = CTM_MD_TMR;
  end

  // comparators and counter clear selection
  always_comb
  begin
    cnt11    = {1'b0, cnt};
    p_len    = (cp == 3'h0) ? `CTM_FULL_PERIOD : {1'b0, cp, 7'h00};
    a_len    = (ma == 10'h000) ? `CTM_FULL_PERIOD : {1'b0, ma};
    per_len  = swap ? a_len : p_len;
    duty_len = swap ? p_len : {1'b0, ma};
    pwm_act  = cnt11 < duty_len;
    ovf      = cnt == `CTM_CNT_MAX;
    if (mode == CTM_MD_PWM)
    begin
      a_hit = cnt11 == ((swap ? a_len : {1'b0, ma}) - 11'h001);
      p_hit = cnt11 == (p_len - 11'h001);
      clr   = swap ? a_hit : p_hit;
      set_a = a_hit;
      set_p = p_hit;
    end
    else
    begin
      a_hit = (ma != 10'h000) && (cnt == ma);
      p_hit = (cp != 3'h0) && (cnt[9:`CTM_P_SHIFT] == cp) &&
              (cnt[`CTM_P_SHIFT-1:0] == 7'h00);
      if (csel)
        clr = a_hit || ((ma == 10'h000) && ovf);
      else
        clr = p_hit || ((cp == 3'h0) && ovf);
      set_a = a_hit;
      set_p = !csel && p_hit;
    end
  end

  // counter, flags and pin state
  always_comb
  begin
    next_cnt       = cnt;
    next_pin_level = pin_level;
    if (run_rise)
    begin
      next_cnt       = `CTM_CNT_RESET;
      next_pin_level = olc;
    end
    else if (step)
    begin
      next_cnt = clr ? `CTM_CNT_RESET : cnt + 10'h001;
      if (mode == CTM_MD_CMP && set_a)
      begin
        case (act)
          `CTM_ACT_LOW:    next_pin_level = 1'b0;
          `CTM_ACT_HIGH:   next_pin_level = 1'b1;
          `CTM_ACT_TOGGLE: next_pin_level = ~pin_level;
          default:         next_pin_level = pin_level;
        endcase
      end
    end
    // hardware set wins over software clear
    next_flag_a = (flag_a & ~(wr && I_PADDR == `CTM_OFF_FLAGS && I_PWDATA[`CTM_FL_A]))
                  | (step & set_a);
    next_flag_p = (flag_p & ~(wr && I_PADDR == `CTM_OFF_FLAGS && I_PWDATA[`CTM_FL_P]))
                  | (step & set_p);
    case (act)
      `CTM_ACT_NONE: lvl = ~olc;
      `CTM_ACT_LOW:  lvl = olc;
      `CTM_ACT_HIGH: lvl = pwm_act ? olc : ~olc;
      default:       lvl = ~olc;
    endcase
    next_pin_oe = mode != CTM_MD_TMR;
    if (mode == CTM_MD_PWM)
      next_pin = lvl ^ inv;
    else if (mode == CTM_MD_CMP)
      next_pin = pin_level ^ inv;
    else
      next_pin = 1'b0;
  end

  // apb slave: access phase lasts two cycles
  always_comb
  begin
    acc          = I_PSEL & I_PENABLE & ~O_PREADY;
    wr           = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
    rd           = acc & ~I_PWRITE;
    next_pready  = acc;
    next_pslverr = 1'b0;
    next_prdata  = O_PRDATA;
    next_ctrl0   = ctrl0;
    next_ctrl1   = ctrl1;
    next_ma      = ma;
    next_cp      = cp;
    if (rd)
    begin
      next_prdata = 32'h0000_0000;
      if (I_PADDR == `CTM_OFF_CTRL0)
        next_prdata[7:0] = ctrl0;
      else if (I_PADDR == `CTM_OFF_CTRL1)
        next_prdata[7:0] = ctrl1;
      else if (I_PADDR == `CTM_OFF_CNT_LO)
        next_prdata[7:0] = cnt[7:0];
      else if (I_PADDR == `CTM_OFF_CNT_HI)
        next_prdata[1:0] = cnt[9:8];
      else if (I_PADDR == `CTM_OFF_MA_LO)
        next_prdata[7:0] = ma[7:0];
      else if (I_PADDR == `CTM_OFF_MA_HI)
        next_prdata[1:0] = ma[9:8];
      else if (I_PADDR == `CTM_OFF_CMP_P)
        next_prdata[2:0] = cp;
      else if (I_PADDR == `CTM_OFF_FLAGS)
        next_prdata[1:0] = {flag_p, flag_a};
      else
        next_pslverr = 1'b1;
    end
    if (wr)
    begin
      if (I_PADDR == `CTM_OFF_CTRL0)
        next_ctrl0 = I_PWDATA[7:0];
      else if (I_PADDR == `CTM_OFF_CTRL1)
        next_ctrl1 = I_PWDATA[7:0];
      else if (I_PADDR == `CTM_OFF_MA_LO)
        next_ma[7:0] = I_PWDATA[7:0];
      else if (I_PADDR == `CTM_OFF_MA_HI)
        next_ma[9:8] = I_PWDATA[1:0];
      else if (I_PADDR == `CTM_OFF_CMP_P)
        next_cp = I_PWDATA[2:0];
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      ctrl0     <= `CTM_CTRL0_RESET;
      ctrl1     <= `CTM_CTRL1_RESET;
      ma        <= `CTM_MA_RESET;
      cp        <= `CTM_CMP_P_RESET;
      flag_a    <= 1'b0;
      flag_p    <= 1'b0;
      cnt       <= `CTM_CNT_RESET;
      run_d     <= 1'b0;
      pin_level <= 1'b0;
      O_PIN     <= 1'b0;
      O_PIN_OE  <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      ctrl0     <= next_ctrl0;
      ctrl1     <= next_ctrl1;
      ma        <= next_ma;
      cp        <= next_cp;
      flag_a    <= next_flag_a;
      flag_p    <= next_flag_p;
      cnt       <= next_cnt;
      run_d     <= run;
      pin_level <= next_pin_level;
      O_PIN     <= next_pin;
      O_PIN_OE  <= next_pin_oe;
      O_PRDATA  <= next_prdata;
      O_PREADY  <= next_pready;
      O_PSLVERR <= next_pslverr;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_hi_write;
    wr && I_PADDR == `CTM_OFF_MA_HI;
  endsequence

  a_cmpa_high_write: assert property (
    s_hi_write |=> ma[9:8] == $past(I_PWDATA[1:0]))
    else $error("compare A high bits not loaded");

  a_timer_pin_free: assert property (
    mode == CTM_MD_TMR |=> !O_PIN_OE && !O_PIN)
    else $error("pin driven in timer mode");

  a_p_match_clear: assert property (
    mode == CTM_MD_CMP && !csel && step && p_hit |=> cnt == 10'h000 && flag_p)
    else $error("P match did not clear counter");

  a_no_p_flag: assert property (
    mode != CTM_MD_PWM && csel && !flag_p |=> !flag_p)
    else $error("P flag raised with clear select high");

  a_wrap_no_a_flag: assert property (
    mode == CTM_MD_CMP && csel && ma == 10'h000 && step && ovf && !flag_a
    |=> cnt == 10'h000 && !flag_a)
    else $error("zero compare A mishandled at wrap");

  sequence s_toggle_hit;
    mode == CTM_MD_CMP && act == `CTM_ACT_TOGGLE && step && set_a;
  endsequence

  a_toggle_pin: assert property (
    s_toggle_hit |=> pin_level != $past(pin_level) ##1 O_PIN == (pin_level ^ inv))
    else $error("toggle on A match failed");

  a_run_initial: assert property (
    $rose(run) |=> pin_level == $past(olc))
    else $error("pin not reset to initial level");

  sequence s_full_duty;
    (mode == CTM_MD_PWM && act == `CTM_ACT_HIGH && !inv && duty_len >= per_len) [*2];
  endsequence

  a_full_duty: assert property (
    s_full_duty |=> O_PIN == olc)
    else $error("full duty not held");

  a_forced_counts: assert property (
    mode == CTM_MD_PWM && act == `CTM_ACT_NONE && step && !clr |=> cnt == $past(cnt) + 10'h001)
    else $error("counter stopped while pin forced");

endmodule

//--- test/ctm_load.sv
`timescale 1ns/1ps
// load on the timer pin; a weak pull-down holds the line while it is undriven
module ctm_load
(
  input  wire logic        i_clk,
  input  wire logic        i_pin,
  input  wire logic        i_oe,
  input  wire logic        i_clr,
  output logic [15:0]      o_high_cnt
);
  logic line;

  assign line = i_oe ? i_pin : 1'b0;

  // counts the cycles that the line spends high since the last clear
  always @(posedge i_clk)
    if (i_clr)
      o_high_cnt <= 16'h0000;
    else if (line)
      o_high_cnt <= o_high_cnt + 16'h0001;
endmodule

//--- test/ctm_top_tb.sv
`timescale 1ns/1ps
`include "ctm_defines.svh"

module ctm_top_tb;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        clr;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        pin_oe;
  logic        err;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] high_cnt;
  int          num_errors;
  int          compares;
  // compare mode cases: control one, then {initial pin, pin after one match}
  logic [7:0]  cm_c1  [5] = '{8'h09, 8'h19, 8'h21, 8'h31, 8'h25};
  logic [1:0]  cm_exp [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h2};
  // pwm cases: control one, compare a, compare p, window, high cycles, flags
  logic [7:0]  pw_c1  [9] = '{8'ha8, 8'ha8, 8'ha8, 8'haa, 8'had, 8'ha0, 8'h88, 8'h98, 8'hb8};
  logic [9:0]  pw_a   [9] = '{10'h040, 10'h0c8, 10'h080, 10'h12c, 10'h020,
                              10'h020, 10'h020, 10'h020, 10'h020};
  logic [2:0]  pw_p   [9] = '{3'h1, 3'h1, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};
  logic [10:0] pw_win [9] = '{11'h100, 11'h100, 11'h400, 11'h258, 11'h100,
                              11'h100, 11'h100, 11'h100, 11'h100};
  logic [10:0] pw_hi  [9] = '{11'h080, 11'h100, 11'h080, 11'h100, 11'h0c0,
                              11'h0c0, 11'h000, 11'h100, 11'h000};
  logic [1:0]  pw_fl  [9] = '{2'h3, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
  // timer clock cases: control zero with run set, cycles for about 0x68 steps
  logic [7:0]  ck_c0  [3] = '{8'h08, 8'h28, 8'h38};
  int          ck_n   [3] = '{416, 1664, 6656};

  ctm_top dut
  (
    .I_CLK     (clk),
    .I_RST_N   (rst_n),
    .I_PSEL    (psel),
    .I_PENABLE (penable),
    .I_PWRITE  (pwrite),
    .I_PADDR   (paddr),
    .I_PWDATA  (pwdata),
    .O_PRDATA  (prdata),
    .O_PREADY  (pready),
    .O_PSLVERR (pslverr),
    .O_PIN     (pin),
    .O_PIN_OE  (pin_oe)
  );

  ctm_load load
  (
    .i_clk      (clk),
    .i_pin      (pin),
    .i_oe       (pin_oe),
    .i_clr      (clr),
    .o_high_cnt (high_cnt)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      num_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // stop, load settings and clear flags, then start at full timer clock
  task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] p);
    apb(1'b1, `CTM_OFF_CTRL0, 32'h10);
    apb(1'b1, `CTM_OFF_CTRL1, {24'h0, c1});
    apb(1'b1, `CTM_OFF_MA_LO, {24'h0, a[7:0]});
    apb(1'b1, `CTM_OFF_MA_HI, {30'h0, a[9:8]});
    apb(1'b1, `CTM_OFF_CMP_P, {29'h0, p});
    apb(1'b1, `CTM_OFF_FLAGS, 32'h3);
    apb(1'b1, `CTM_OFF_CTRL0, 32'h18);
  endtask

  initial
  begin
    num_errors = 0;
    compares = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clr = 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rc(`CTM_OFF_MA_HI, 32'h0);
    apb(1'b1, `CTM_OFF_MA_HI, 32'hff);
    rc(`CTM_OFF_MA_HI, 32'h3);
    apb(1'b1, `CTM_OFF_MA_LO, 32'ha5);
    rc(`CTM_OFF_MA_LO, 32'ha5);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h20, 32'h5);
    chk({31'h0, err}, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      cfg(cm_c1[i], 10'h100, 3'h1);
      cyc(3);
      chk({31'h0, pin}, {31'h0, cm_exp[i][1]});
      cyc(300);
      chk({31'h0, pin}, {31'h0, cm_exp[i][0]});
      rc(`CTM_OFF_FLAGS, 32'h1);
    end
    cfg(8'h20, 10'h005, 3'h1);
    cyc(300);
    rc(`CTM_OFF_FLAGS, 32'h3);
    rc(`CTM_OFF_CNT_HI, 32'h0);
    chk({31'h0, pin}, 32'h1);
    cfg(8'h21, 10'h000, 3'h1);
    cyc(600);
    rc(`CTM_OFF_CNT_HI, 32'h2);
    cyc(500);
    rc(`CTM_OFF_FLAGS, 32'h0);
    cfg(8'he1, 10'h020, 3'h1);
    cyc(100);
    chk({30'h0, pin_oe, pin}, 32'h0);
    rc(`CTM_OFF_FLAGS, 32'h1);
    for (int i = 0; i < 9; i++)
    begin
      cfg(pw_c1[i], pw_a[i], pw_p[i]);
      cyc(20);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      cyc(pw_win[i]);
      #1;
      chk({16'h0, high_cnt}, {21'h0, pw_hi[i]});
      rc(`CTM_OFF_FLAGS, {30'h0, pw_fl[i]});
    end
    cfg(8'h61, 10'h000, 3'h0);
    cyc(4);
    chk({30'h0, pin_oe, pin}, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, `CTM_OFF_CTRL0, {24'h0, ck_c0[i] & 8'hf7});
      apb(1'b1, `CTM_OFF_CTRL0, {24'h0, ck_c0[i]});
      cyc(ck_n[i]);
      apb(1'b0, `CTM_OFF_CNT_LO, 32'h0);
      chk(rd & 32'h0000_00f0, 32'h0000_0060);
    end
    tally_and_finish();
  end

  // the whole run needs some sixteen thousand cycles
  initial
  begin
    #(25 * 40000);
    num_errors++;
    tally_and_finish();
  end
endmodule
